// ### hw/vmr_pkg.sv
// Package with register map, field layout, reset values and states of the bus requester.
package vmr_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [7:0] VMR_MASTER_CONTROL_OFS = 8'h00;
	localparam logic [7:0] VMR_STATUS_OFS = 8'h04;
	localparam logic [7:0] VMR_OFF_TIME_OFS = 8'h08;
	localparam logic [7:0] VMR_IRQ_ENABLE_OFS = 8'h0C;

	// Field positions inside master_control.
	localparam int VMR_LEVEL_LSB = 0;
	localparam int VMR_REQ_MODE_BIT = 2;
	localparam int VMR_REL_MODE_BIT = 3;
	localparam int VMR_OWN_REQ_BIT = 4;
	localparam int VMR_ACK_IRQ_EN_BIT = 5;
	localparam int VMR_OFF_EN_BIT = 6;
	localparam int VMR_POSTED_TENURE_BYTE_LIMIT_LSB = 8;

	// Field positions inside the status register.
	localparam int VMR_ACK_BIT = 0;
	localparam int VMR_BUSY_BIT = 1;
	localparam int VMR_FIFO_EMPTY_BIT = 2;
	localparam int VMR_GRANT_LSB = 3;
	localparam int VMR_OFF_ACTIVE_BIT = 6;

	// Reset values of the writable fields.
	localparam logic [1:0] VMR_LEVEL_RST = 2'h3;
	localparam logic [3:0] VMR_POSTED_TENURE_BYTE_LIMIT_RST = 4'h0;
	localparam logic [15:0] VMR_OFF_TIME_RST = 16'h0000;

	// Tenure byte limit code meaning one posted write per tenure.
	localparam logic [3:0] VMR_POSTED_TENURE_BYTE_LIMIT_SINGLE = 4'hF;
	// Smallest tenure byte limit; each code step doubles it.
	localparam logic [23:0] VMR_POSTED_TENURE_BYTE_LIMIT_BASE = 24'h000080;

	// DMA request threshold in bytes.
	localparam logic [15:0] VMR_DMA_THRESHOLD = 16'h0040;

	// Requester states.
	typedef enum logic [1:0]
	{
		VMR_IDLE = 2'b00,
		VMR_REQ = 2'b01,
		VMR_OWN = 2'b10,
		VMR_HOLD = 2'b11
	} vmr_state_t;

	// One-hot grant positions.
	localparam int VMR_CH_IRQ = 0;
	localparam int VMR_CH_PCI = 1;
	localparam int VMR_CH_DMA = 2;

endpackage

// ### hw/vmr_vme_master_requester.sv
// Bus requester and internal arbiter for the VMEbus master interface.
//
// The address map and the APB register port were chosen for this implementation.
module vmr_vme_master_requester
	import vmr_pkg::*;
#(
	parameter int FIFO_CNT_W = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:1] irq_line_n,
	input wire logic iack_done,
	input wire logic ptx_txn_ready,
	input wire logic ptx_fifo_empty,
	input wire logic pw_done,
	input wire logic [11:0] pw_bytes,
	input wire logic coupled_req,
	input wire logic coupled_done,
	input wire logic coupled_window_expired,
	input wire logic coupled_req_timeout,
	input wire logic dma_to_vme,
	input wire logic [FIFO_CNT_W-1:0] dma_fifo_used,
	input wire logic [FIFO_CNT_W-1:0] dma_fifo_free,
	input wire logic dma_fifo_full,
	input wire logic dma_fifo_empty,
	input wire logic dma_error,
	input wire logic dma_tenure_expired,
	input wire logic dma_block_done,
	input wire logic [3:0] br_i_n,
	output logic [3:0] br_o,
	output logic [3:0] br_oe,
	input wire logic bus_grant_in,
	input wire logic bbsy_i_n,
	output logic bbsy_o,
	output logic bbsy_oe,
	output logic [2:0] grant,
	output logic own_ack_irq
);

	// Writable control fields.
	logic [1:0] level_r; // Request level field.
	logic req_mode_r; // One selects fair mode.
	logic rel_mode_r; // One selects release on request.
	logic own_req_r; // Software ownership request.
	logic ack_irq_en_r; // Enables the acknowledge interrupt toward PCI.
	logic off_en_r; // Enables the DMA off-timer.
	logic [3:0] posted_tenure_byte_limit_r; // Posted tenure byte limit code.
	logic [15:0] off_time_r; // DMA off time in clock cycles.
	logic [7:1] irq_en_r; // Interrupt line enables.

	// Requester state.
	vmr_state_t state_r;
	vmr_state_t state_nxt;
	logic [2:0] grant_r; // Channel owning the master interface.
	logic [2:0] grant_nxt; // Channel picked at this arbitration point.
	logic last_pci_r; // PCI won the last contested arbitration.
	logic ack_r; // Ownership acknowledge.
	logic [23:0] pw_count_r; // Bytes moved in this PCI tenure.
	logic [15:0] off_cnt_r; // Remaining DMA off time.
	logic [3:0] br_oe_r;
	logic bbsy_oe_r;
	logic own_ack_irq_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// Combinational request and done terms.
	logic irq_req;
	logic pci_req;
	logic dma_req;
	logic irq_dn;
	logic pci_dn;
	logic dma_dn;
	logic owner_done;
	logic ext_pending;
	logic level_free;
	logic need_bus;
	logic [23:0] pw_limit;
	logic [23:0] pw_sum;
	logic apb_write;
	logic apb_setup;

	// Outputs come straight from flip-flops; the open-drain data lines only ever pull low.
	assign br_oe = br_oe_r;
	assign bbsy_oe = bbsy_oe_r;
	assign grant = grant_r;
	assign own_ack_irq = own_ack_irq_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// The driven level of each open-drain line is a constant low held in a flip-flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			br_o <= 4'h0;
			bbsy_o <= 1'b0;
		end
		else
		begin
			br_o <= 4'h0;
			bbsy_o <= 1'b0;
		end
	end

	// Channel request terms.
	always_comb
	begin
		irq_req = |(~irq_line_n & irq_en_r);
		pci_req = ptx_txn_ready | coupled_req;
		if (dma_to_vme)
		begin
			dma_req = (dma_fifo_used >= VMR_DMA_THRESHOLD[FIFO_CNT_W-1:0]);
		end
		else
		begin
			dma_req = (dma_fifo_free >= VMR_DMA_THRESHOLD[FIFO_CNT_W-1:0]);
		end
		dma_req = (dma_req | dma_block_done) & (off_cnt_r == 16'h0000) & ~own_req_r;
	end

	// Done terms of each channel.
	always_comb
	begin
		pw_sum = pw_count_r + {12'h000, pw_bytes};
		pw_limit = VMR_POSTED_TENURE_BYTE_LIMIT_BASE << posted_tenure_byte_limit_r;
		irq_dn = iack_done;
		// A posted write finishing ends the tenure on empty FIFO, single mode, or byte limit while no ownership request is set.
		pci_dn = pw_done & (ptx_fifo_empty | (posted_tenure_byte_limit_r == VMR_POSTED_TENURE_BYTE_LIMIT_SINGLE)
			| (~own_req_r & (pw_sum >= pw_limit)));
		pci_dn = pci_dn | (coupled_done & coupled_window_expired) | coupled_req_timeout;
		if (dma_to_vme)
		begin
			dma_dn = dma_fifo_empty;
		end
		else
		begin
			dma_dn = dma_fifo_full;
		end
		dma_dn = dma_dn | dma_error | dma_tenure_expired | dma_block_done;
		owner_done = (grant_r[VMR_CH_IRQ] & irq_dn) | (grant_r[VMR_CH_PCI] & pci_dn)
			| (grant_r[VMR_CH_DMA] & dma_dn);
	end

	// Bus-side observations; the bus clear line has no input here at all.
	always_comb
	begin
		ext_pending = ~&br_i_n;
		level_free = br_i_n[level_r];
		need_bus = irq_req | pci_req | dma_req | (own_req_r & ~ack_r);
	end

	// Internal arbitration: interrupt first, then PCI and DMA in turn.
	always_comb
	begin
		grant_nxt = 3'h0;
		if (irq_req)
		begin
			grant_nxt[VMR_CH_IRQ] = 1'b1;
		end
		else if (pci_req && dma_req)
		begin
			// Both waiting: the loser of the last contest goes now.
			grant_nxt[VMR_CH_DMA] = last_pci_r;
			grant_nxt[VMR_CH_PCI] = ~last_pci_r;
		end
		else if (pci_req)
		begin
			grant_nxt[VMR_CH_PCI] = 1'b1;
		end
		else if (dma_req)
		begin
			grant_nxt[VMR_CH_DMA] = 1'b1;
		end
	end

	// Next state of the requester.
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			VMR_IDLE:
			begin
				// Fair mode holds back while the own level is busy.
				if (need_bus && (!req_mode_r || level_free))
				begin
					state_nxt = VMR_REQ;
				end
			end
			VMR_REQ:
			begin
				// Bus won once the grant arrives and nobody else is busy.
				if (bus_grant_in && bbsy_i_n)
				begin
					state_nxt = (grant_nxt != 3'h0) ? VMR_OWN : VMR_HOLD;
				end
			end
			VMR_OWN:
			begin
				if (owner_done)
				begin
					if (own_req_r || (rel_mode_r && !ext_pending))
					begin
						state_nxt = VMR_HOLD;
					end
					else
					begin
						state_nxt = VMR_IDLE;
					end
				end
			end
			VMR_HOLD:
			begin
				if (own_req_r || (rel_mode_r && !ext_pending))
				begin
					// Channels take over the held bus without arbitration.
					if (grant_nxt != 3'h0)
					begin
						state_nxt = VMR_OWN;
					end
				end
				else
				begin
					state_nxt = VMR_IDLE;
				end
			end
			default:
			begin
				state_nxt = VMR_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= VMR_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// Grant register and fairness memory.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			grant_r <= 3'h0;
			last_pci_r <= 1'b0;
		end
		else
		begin
			if (state_nxt == VMR_OWN && state_r != VMR_OWN)
			begin
				grant_r <= grant_nxt;
				if (pci_req && dma_req && !irq_req)
				begin
					last_pci_r <= grant_nxt[VMR_CH_PCI];
				end
			end
			else if (state_nxt != VMR_OWN)
			begin
				grant_r <= 3'h0;
			end
		end
	end

	// Bus request and busy drivers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			br_oe_r <= 4'h0;
			bbsy_oe_r <= 1'b0;
		end
		else
		begin
			br_oe_r <= 4'h0;
			if (state_nxt == VMR_REQ)
			begin
				br_oe_r[level_r] <= 1'b1;
			end
			bbsy_oe_r <= (state_nxt == VMR_OWN) || (state_nxt == VMR_HOLD);
		end
	end

	// Ownership acknowledge follows the software bit once the bus is held.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_r <= 1'b0;
			own_ack_irq_r <= 1'b0;
		end
		else
		begin
			ack_r <= own_req_r & (ack_r | bbsy_oe_r);
			own_ack_irq_r <= ack_irq_en_r & own_req_r & (ack_r | bbsy_oe_r);
		end
	end

	// Bytes moved by the PCI channel in its current tenure.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pw_count_r <= 24'h000000;
		end
		else if (!grant_r[VMR_CH_PCI])
		begin
			pw_count_r <= 24'h000000;
		end
		else if (pw_done)
		begin
			pw_count_r <= pw_sum;
		end
	end

	// DMA off-timer, loaded when the DMA channel gives up the interface.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			off_cnt_r <= 16'h0000;
		end
		else if (off_en_r && grant_r[VMR_CH_DMA] && dma_dn)
		begin
			off_cnt_r <= off_time_r;
		end
		else if (off_cnt_r != 16'h0000)
		begin
			off_cnt_r <= off_cnt_r - 16'h0001;
		end
	end

	// APB strobes: zero-wait slave, write takes effect in the access cycle.
	always_comb
	begin
		apb_setup = psel & ~penable;
		apb_write = psel & penable & pready_r & pwrite;
	end

	// Software-writable control registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			level_r <= VMR_LEVEL_RST;
			req_mode_r <= 1'b0;
			rel_mode_r <= 1'b0;
			own_req_r <= 1'b0;
			ack_irq_en_r <= 1'b0;
			off_en_r <= 1'b0;
			posted_tenure_byte_limit_r <= VMR_POSTED_TENURE_BYTE_LIMIT_RST;
			off_time_r <= VMR_OFF_TIME_RST;
			irq_en_r <= 7'h00;
		end
		else if (apb_write)
		begin
			case (paddr)
				VMR_MASTER_CONTROL_OFS:
				begin
					level_r <= pwdata[VMR_LEVEL_LSB +: 2];
					req_mode_r <= pwdata[VMR_REQ_MODE_BIT];
					rel_mode_r <= pwdata[VMR_REL_MODE_BIT];
					own_req_r <= pwdata[VMR_OWN_REQ_BIT];
					ack_irq_en_r <= pwdata[VMR_ACK_IRQ_EN_BIT];
					off_en_r <= pwdata[VMR_OFF_EN_BIT];
					posted_tenure_byte_limit_r <= pwdata[VMR_POSTED_TENURE_BYTE_LIMIT_LSB +: 4];
				end
				VMR_OFF_TIME_OFS:
				begin
					off_time_r <= pwdata[15:0];
				end
				VMR_IRQ_ENABLE_OFS:
				begin
					irq_en_r <= pwdata[7:1];
				end
				default:
				begin
					off_time_r <= off_time_r;
				end
			endcase
		end
	end

	// Read data, ready and error are captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= apb_setup;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
			if (apb_setup)
			begin
				case (paddr)
					VMR_MASTER_CONTROL_OFS:
					begin
						prdata_r[VMR_LEVEL_LSB +: 2] <= level_r;
						prdata_r[VMR_REQ_MODE_BIT] <= req_mode_r;
						prdata_r[VMR_REL_MODE_BIT] <= rel_mode_r;
						prdata_r[VMR_OWN_REQ_BIT] <= own_req_r;
						prdata_r[VMR_ACK_IRQ_EN_BIT] <= ack_irq_en_r;
						prdata_r[VMR_OFF_EN_BIT] <= off_en_r;
						prdata_r[VMR_POSTED_TENURE_BYTE_LIMIT_LSB +: 4] <= posted_tenure_byte_limit_r;
					end
					VMR_STATUS_OFS:
					begin
						prdata_r[VMR_ACK_BIT] <= ack_r;
						prdata_r[VMR_BUSY_BIT] <= bbsy_oe_r;
						prdata_r[VMR_FIFO_EMPTY_BIT] <= ptx_fifo_empty;
						prdata_r[VMR_GRANT_LSB +: 3] <= grant_r;
						prdata_r[VMR_OFF_ACTIVE_BIT] <= (off_cnt_r != 16'h0000);
					end
					VMR_OFF_TIME_OFS:
					begin
						prdata_r[15:0] <= off_time_r;
					end
					VMR_IRQ_ENABLE_OFS:
					begin
						prdata_r[7:1] <= irq_en_r;
					end
					default:
					begin
						pslverr_r <= 1'b1; // Unmapped address answers with an error.
					end
				endcase
			end
		end
	end

endmodule

// ### testbench/vmr_arb_model.sv
// Behavioural model of the system arbiter and the other bus masters.
module vmr_arb_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] br_oe,
	input wire logic bbsy_oe,
	input wire logic [3:0] ext_br,
	output logic [3:0] br_i_n,
	output logic bbsy_i_n,
	output logic bus_grant_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_r;
	// Request lines have pull-ups, so any master pulls its line low.
	assign br_i_n = ~(br_oe | ext_br);
	assign bbsy_i_n = ~bbsy_oe;
	// Grant comes a few cycles after our request while the bus is idle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_r <= 2'h0;
			bus_grant_in <= 1'h0;
		end
		else if ((|br_oe) && bbsy_i_n)
		begin
			wait_r <= wait_r + ((wait_r == 2'h3) ? 2'h0 : 2'h1);
			bus_grant_in <= (wait_r == 2'h3);
		end
		else
		begin
			wait_r <= 2'h0;
			bus_grant_in <= 1'h0;
		end
	end
endmodule

// ### testbench/vmr_vme_master_requester_sva.sv
// Port assertions for the bus requester.
module vmr_sva_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] br_o,
	input wire logic [3:0] br_oe,
	input wire logic bbsy_o,
	input wire logic bbsy_oe,
	input wire logic bus_grant_in,
	input wire logic bbsy_i_n,
	input wire logic iack_done,
	input wire logic pw_done,
	input wire logic ptx_fifo_empty,
	input wire logic dma_error,
	input wire logic [2:0] grant,
	input wire logic own_ack_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_grant_onehot: assert property ($onehot0(grant))
		else $error("grant not one-hot");
	chk_level_single: assert property ($onehot0(br_oe) && br_o == 4'h0 && !bbsy_o)
		else $error("bad request lines");
	chk_owner_busy: assert property (|grant |-> bbsy_oe)
		else $error("owner without busy");
	chk_no_preempt: assert property (|grant |=> grant == $past(grant) || grant == 3'h0)
		else $error("owner switched directly");
	chk_win_granted: assert property ($rose(bbsy_oe) |-> $past(bus_grant_in) && $past(bbsy_i_n))
		else $error("busy taken without grant");
	chk_req_dropped: assert property ($rose(bbsy_oe) |-> br_oe == 4'h0)
		else $error("request kept after winning");
	chk_irq_done: assert property (grant[0] && iack_done |=> grant == 3'h0)
		else $error("irq channel kept");
	chk_dma_done: assert property (grant[2] && dma_error |=> grant == 3'h0)
		else $error("dma channel kept");
	chk_pci_done: assert property (grant[1] && pw_done && ptx_fifo_empty |=> grant == 3'h0)
		else $error("pci channel kept");
	chk_ack_busy: assert property (own_ack_irq |-> bbsy_oe)
		else $error("ack without busy");
	cover property (grant[0]);
	cover property (grant[2]);
	cover property ($fell(bbsy_oe));
endmodule
bind vmr_vme_master_requester vmr_sva_chk chk_u (.pclk, .presetn, .br_o, .br_oe, .bbsy_o,
	.bbsy_oe, .bus_grant_in, .bbsy_i_n, .iack_done, .pw_done, .ptx_fifo_empty, .dma_error,
	.grant, .own_ack_irq);

// ### testbench/tb_vme_master_requester.sv
// Self-checking testbench for the bus requester.
module tb_vme_master_requester import vmr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, bbsy_o, bbsy_oe, gi, bb_n, own_ack_irq;
	logic [7:1] irq_n = 7'h7F;
	logic iack = 1'h0, txr = 1'h0, tfe = 1'h1, pwd = 1'h0, derr = 1'h0, dq = 1'h0;
	logic [15:0] dfree = 16'h0, dused = 16'h0;
	logic cpl_req = 1'h0, cpl_done = 1'h0, cpl_win = 1'h0, cpl_to = 1'h0;
	logic dfx = 1'h0, dblk = 1'h0;
	logic [11:0] pwb = 12'h4;
	logic [3:0] br_i_n, br_o, br_oe, ext_br = 4'h0;
	logic [2:0] grant;
	int n_errors = 0, cmp_count = 0;
	vmr_vme_master_requester #(.FIFO_CNT_W(16)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_line_n(irq_n),
		.iack_done(iack), .ptx_txn_ready(txr), .ptx_fifo_empty(tfe), .pw_done(pwd),
		.pw_bytes(pwb), .coupled_req(cpl_req), .coupled_done(cpl_done),
		.coupled_window_expired(cpl_win), .coupled_req_timeout(cpl_to), .dma_to_vme(dq),
		.dma_fifo_used(dused), .dma_fifo_free(dfree), .dma_fifo_full(dfx),
		.dma_fifo_empty(dfx), .dma_error(derr), .dma_tenure_expired(1'h0),
		.dma_block_done(dblk), .br_i_n, .br_o,
		.br_oe, .bus_grant_in(gi), .bbsy_i_n(bb_n), .bbsy_o, .bbsy_oe, .grant, .own_ack_irq);
	vmr_arb_model arb_u (.pclk, .presetn, .br_oe, .bbsy_oe, .ext_br, .br_i_n,
		.bbsy_i_n(bb_n), .bus_grant_in(gi));
	initial
	begin
		forever #50 pclk = ~pclk;
	end
	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, VMR_MASTER_CONTROL_OFS, d, r, e);
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? bbsy_oe : k == 1 ? |grant : |br_oe;
	endfunction
	// Bounded wait on busy, any grant or any request; a timeout shows as a mismatch.
	task automatic wt(input int k, input logic v);
		for (int i = 0; i < 300 && sig(k) !== v; i++)
			@(posedge pclk);
		cmp(sig(k), v);
	endtask
	// Ends a PCI or DMA owner's tenure by its own done event; any non-PCI owner gets dma_error.
	task automatic done(input logic [2:0] g);
		if (g[1])
			pwd <= 1'h1;
		else
			derr <= 1'h1;
		@(posedge pclk);
		pwd <= 1'h0;
		derr <= 1'h0;
		wt(1, 1'h0);
		wt(0, 1'h0);
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		cmp({br_oe, bbsy_oe, grant}, 8'h0);
		apb(1'h0, VMR_MASTER_CONTROL_OFS, 32'h0, r, e);
		cmp(r, 32'h3);
		apb(1'h0, VMR_STATUS_OFS, 32'h0, r, e);
		cmp(r, 32'h4);
		apb(1'h0, 8'h10, 32'h0, r, e);
		cmp({e, r[30:0]}, 32'h80000000);
	endtask
	task automatic t_levels();
		logic [31:0] r;
		logic e;
		for (int lv = 0; lv < 4; lv++)
		begin
			wr(lv);
			txr <= 1'h1;
			wt(2, 1'h1);
			cmp(br_oe, 4'h1 << lv);
			wt(0, 1'h1);
			cmp(grant, 3'h2);
			apb(1'h0, VMR_STATUS_OFS, 32'h0, r, e);
			cmp(r[VMR_BUSY_BIT], 1'h1);
			txr <= 1'h0;
			done(3'h2);
		end
	endtask
	task automatic t_prio();
		logic [2:0] g;
		logic [31:0] r;
		logic e;
		irq_n[5] <= 1'h0;
		cyc(10);
		cmp(br_oe, 4'h0);
		irq_n[5] <= 1'h1;
		apb(1'h1, VMR_IRQ_ENABLE_OFS, 32'h8, r, e);
		wr(32'hF03);
		tfe <= 1'h0;
		irq_n[3] <= 1'h0;
		txr <= 1'h1;
		dfree <= 16'h40;
		wt(1, 1'h1);
		cmp(grant, 3'h1);
		irq_n[3] <= 1'h1;
		iack <= 1'h1;
		@(posedge pclk);
		iack <= 1'h0;
		wt(1, 1'h0);
		wt(1, 1'h1);
		g = grant;
		done(g);
		wt(1, 1'h1);
		cmp(grant, g ^ 3'h6);
		txr <= 1'h0;
		dfree <= 16'h0;
		done(grant);
		tfe <= 1'h1;
	endtask
	task automatic t_own();
		logic [31:0] r;
		logic e;
		wr(32'h33);
		wt(0, 1'h1);
		cyc(2);
		apb(1'h0, VMR_STATUS_OFS, 32'h0, r, e);
		cmp(r[1:0], 2'h3);
		cmp(own_ack_irq, 1'h1);
		dfree <= 16'h40;
		cyc(20);
		cmp({bbsy_oe, grant}, 4'h8);
		wr(32'h3);
		wt(1, 1'h1);
		cmp(grant, 3'h4);
		dfree <= 16'h0;
		done(3'h4);
	endtask
	task automatic t_fair();
		ext_br[3] <= 1'h1;
		txr <= 1'h1;
		wt(2, 1'h1);
		wt(1, 1'h1);
		txr <= 1'h0;
		done(3'h2);
		wr(32'h7);
		txr <= 1'h1;
		cyc(10);
		cmp(br_oe, 4'h0);
		ext_br[3] <= 1'h0;
		wt(1, 1'h1);
		txr <= 1'h0;
		done(3'h2);
	endtask
	task automatic t_ror();
		wr(32'hB);
		txr <= 1'h1;
		wt(1, 1'h1);
		txr <= 1'h0;
		pwd <= 1'h1;
		@(posedge pclk);
		pwd <= 1'h0;
		cyc(2);
		cmp({bbsy_oe, grant}, 4'h8);
		dfree <= 16'h40;
		wt(1, 1'h1);
		cmp({bbsy_oe, grant, br_oe}, 8'hC0);
		dfree <= 16'h0;
		ext_br[0] <= 1'h1;
		cyc(3);
		cmp({bbsy_oe, grant}, 4'hC);
		done(3'h4);
		ext_br[0] <= 1'h0;
	endtask
	// Coupled cycle: done only with the window expired, or on the request timeout.
	task automatic t_cpl();
		cpl_req <= 1'h1;
		wt(1, 1'h1);
		cmp(grant, 3'h2);
		cpl_done <= 1'h1;
		cyc(3);
		cmp(grant, 3'h2);
		cpl_win <= 1'h1;
		@(posedge pclk);
		{cpl_done, cpl_win} <= 2'h0;
		wt(1, 1'h0);
		wt(1, 1'h1);
		cpl_req <= 1'h0;
		cpl_to <= 1'h1;
		@(posedge pclk);
		cpl_to <= 1'h0;
		wt(1, 1'h0);
		wt(0, 1'h0);
	endtask
	// Smallest tenure limit: two writes of half that size end the tenure.
	task automatic t_limit();
		tfe <= 1'h0;
		txr <= 1'h1;
		pwb <= VMR_POSTED_TENURE_BYTE_LIMIT_BASE[12:1];
		wt(1, 1'h1);
		txr <= 1'h0;
		pwd <= 1'h1;
		@(posedge pclk);
		pwd <= 1'h0;
		cyc(2);
		cmp(grant, 3'h2);
		done(3'h2);
		tfe <= 1'h1;
		pwb <= 12'h4;
	endtask
	// DMA toward the bus: FIFO empty and block complete end it; the off-timer holds it back.
	task automatic t_off();
		logic [31:0] r;
		logic e;
		apb(1'h1, VMR_OFF_TIME_OFS, 32'h20, r, e);
		wr(32'h43);
		dq <= 1'h1;
		dused <= VMR_DMA_THRESHOLD;
		wt(1, 1'h1);
		cmp(grant, 3'h4);
		dfx <= 1'h1;
		@(posedge pclk);
		dfx <= 1'h0;
		wt(1, 1'h0);
		cyc(20);
		cmp(br_oe, 4'h0);
		dused <= 16'h0;
		dblk <= 1'h1;
		wt(1, 1'h1);
		dblk <= 1'h0;
		cmp(grant, 3'h4);
		wt(0, 1'h0);
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset();
		t_levels();
		t_cpl();
		t_limit();
		t_prio();
		t_own();
		t_fair();
		t_ror();
		t_off();
		test_done();
	end
endmodule
